// ===== design/adc_regs.svh
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH
// i/o register addresses
`define ADC_REF_CTRL_ADDR 6'h1C
`define ADC_CTRL_ADDR 6'h20
`define ADC_CLKDIV_ADDR 6'h21
`define ADC_RESULT_ADDR 6'h22
// control register fields
`define ADC_CTRL_EN_BIT 7
`define ADC_CTRL_GO_BIT 6
`define ADC_CTRL_CH_HI 5
`define ADC_CTRL_CH_LO 2
// clock divider field
`define ADC_DIV_HI 4
`define ADC_DIV_LO 1
`define ADC_DIV_MAX 4'h7
// reference control fields
`define ADC_REF_SEL_HI 7
`define ADC_REF_SEL_LO 4
`define ADC_REF_OUT_BIT 0
// reset values
`define ADC_CH_RST 4'h0
`define ADC_DIV_RST 4'h0
`define ADC_REF_SEL_RST 4'h0
// converter clocks per conversion (one per bit plus one sample slot)
`define ADC_CONV_TICKS 4'h9
`endif

// ===== design/adc_pkg.sv
package adc_pkg;
  // conversion sequencer states
  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_CONV,
    ADC_DONE
  } adc_state_t;
  // channel codes
  typedef enum logic [3:0] {
    ADC_CH_PB0 = 4'h0,
    ADC_CH_PB1 = 4'h1,
    ADC_CH_PB2 = 4'h2,
    ADC_CH_PB3 = 4'h3,
    ADC_CH_PB7 = 4'h7,
    ADC_CH_PA3 = 4'h8,
    ADC_CH_PA4 = 4'h9,
    ADC_CH_BG = 4'hF
  } adc_chan_t;
  // high reference codes
  typedef enum logic [3:0] {
    ADC_REF_VDD = 4'h0,
    ADC_REF_PB1 = 4'h1,
    ADC_REF_BG = 4'h2
  } adc_ref_t;
endpackage : adc_pkg

// ===== design/adc_clk_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_regs.svh"
// converter clock tick generator: one-cycle pulse every 2^div_sel clocks, every 128 clocks for codes above 7
module adc_clk_div (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] div_sel,
  input wire logic run,
  output logic tick
);
  logic [6:0] cnt_ff; // free count, cleared while idle
  logic [6:0] nxt_cnt;
  logic [6:0] limit; // terminal value for the chosen division

  // reserved codes fall back to the slowest legal rate rather than misbehave
  always_comb begin
    if (div_sel > `ADC_DIV_MAX) begin
      limit = 7'h7F;
    end else begin
      limit = 7'((8'h01 << div_sel) - 8'h01);
    end
    nxt_cnt = 7'h00;
    tick = 1'b0;
    if (run) begin
      if (cnt_ff >= limit) begin
        tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 7'h01;
      end
    end
  end

  // counter register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : adc_clk_div
`default_nettype wire

// ===== design/adc_sar.sv
`timescale 1ns/1ns
`default_nettype none
`include "adc_regs.svh"
// successive approximation engine, one bit decided per converter tick
module adc_sar (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic tick,
  input wire logic comp_hi,
  output logic [7:0] dac_code,
  output logic busy,
  output logic done,
  output logic [7:0] result
);
  logic [7:0] code_ff; // trial code sent to the comparator dac
  logic [7:0] nxt_code;
  logic [7:0] bit_ff; // one-hot bit under trial, zero during sample slot
  logic [7:0] nxt_bit;
  logic busy_ff;
  logic nxt_busy;
  logic sampled_ff; // sample slot already taken
  logic nxt_sampled;

  // first tick samples, next eight each decide one bit msb first
  always_comb begin
    nxt_code = code_ff;
    nxt_bit = bit_ff;
    nxt_busy = busy_ff;
    nxt_sampled = sampled_ff;
    done = 1'b0;
    if (start) begin
      nxt_code = 8'h00;
      nxt_bit = 8'h00;
      nxt_busy = 1'b1;
      nxt_sampled = 1'b0;
    end else if (busy_ff && tick) begin
      if (!sampled_ff) begin
        nxt_sampled = 1'b1;
        nxt_bit = 8'h80;
        nxt_code = 8'h80;
      end else begin
        // keep the bit if input is above the trial level
        nxt_code = comp_hi ? code_ff : (code_ff & ~bit_ff);
        nxt_bit = bit_ff >> 1;
        nxt_code = nxt_code | (bit_ff >> 1);
        if (bit_ff == 8'h01) begin
          nxt_busy = 1'b0;
          done = 1'b1;
        end
      end
    end
    result = comp_hi ? code_ff : (code_ff & ~bit_ff);
    dac_code = code_ff;
    busy = busy_ff;
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_ff <= 8'h00;
      bit_ff <= 8'h00;
      busy_ff <= 1'b0;
      sampled_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      bit_ff <= nxt_bit;
      busy_ff <= nxt_busy;
      sampled_ff <= nxt_sampled;
    end
  end
endmodule : adc_sar
`default_nettype wire

// ===== design/adc_ctrl.sv
// Function
// - control bit 7 enables converter, resets 0
// - writing bit 6 while already enabled starts, clears done
// - bit 6 reads done flag
// - bits 5..2 select input channel
// - divider field picks clock divide 1..128
// - divider register cannot be read back
// - result register read-only, eight bits
// - reference bits 7..4 select high reference
// - reference bit 0 drives reference out
// - only pin 1 or band-gap routed out
`timescale 1ns/1ns
`default_nettype none
`include "adc_regs.svh"
module adc_ctrl (
  // clock and asynchronous active-low reset
  input wire logic core_clk,
  input wire logic rst_b,
  // processor i/o register port
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // analog front end controls
  input wire logic comp_hi,
  output logic [7:0] dac_code,
  output logic adc_enable,
  output logic [3:0] chan_sel,
  output logic [3:0] ref_sel,
  output logic ref_out_pb1,
  output logic ref_out_bg,
  output logic adc_clk_tick
);
  // register state, each flop paired with its next value
  logic en_ff; // converter enable
  logic nxt_en;
  logic done_ff; // completion flag
  logic nxt_done;
  logic [3:0] ch_ff; // channel select
  logic [3:0] nxt_ch;
  logic [3:0] div_ff; // clock divide code, write only
  logic [3:0] nxt_div;
  logic [3:0] rsel_ff; // high reference select
  logic [3:0] nxt_rsel;
  logic rout_ff; // reference output enable
  logic nxt_rout;
  logic [7:0] res_ff; // last conversion result
  logic [7:0] nxt_res;
  logic [7:0] rdata_ff; // read data, held one cycle after the read strobe
  logic [7:0] nxt_rdata;
  // reference routing switches, one flop per source
  logic pb1_ff; // pin 1 level switched out to pin 2
  logic nxt_pb1;
  logic bg_ff; // band-gap switched out to pin 2
  logic nxt_bg;
  logic tick_ff; // converter clock pulse seen from outside
  logic nxt_tick;
  // engine side
  logic start; // accepted start pulse
  logic tick; // converter clock pulse into the engine
  logic busy; // a conversion is in flight
  logic sar_done; // last bit decided this cycle
  logic [7:0] sar_result; // result that goes with sar_done
  logic [7:0] sar_code; // trial code held in the engine's own flop
  // register port decode
  logic wr_ctrl; // write to the control register
  logic wr_div; // write to the clock divider register
  logic wr_ref; // write to the reference control register

  // one write strobe decode shared by every writable register
  function automatic logic wr_hit(
    input logic wr,
    input logic [5:0] addr,
    input logic [5:0] target
  );
    // a read on the same address never counts as a write
    return wr && (addr == target);
  endfunction : wr_hit

  // address decode for the three writable registers
  assign wr_ctrl = wr_hit(io_wr, io_addr, `ADC_CTRL_ADDR);
  assign wr_div = wr_hit(io_wr, io_addr, `ADC_CLKDIV_ADDR);
  assign wr_ref = wr_hit(io_wr, io_addr, `ADC_REF_CTRL_ADDR);
  // the result address has no write decode at all, so writes there are lost
  // a start on a disabled converter, or one enabled by the same write, is dropped
  assign start = wr_ctrl && io_wdata[`ADC_CTRL_GO_BIT] && en_ff;

  // tick generator only runs during a conversion to save power
  // limitation: a restart mid-count keeps the old count, so its first tick may come early
  adc_clk_div u_div (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .div_sel(div_ff),
    .run(busy),
    .tick(tick)
  );

  // bit-decision engine
  // its trial code goes to the dac straight from its flop, with no extra stage
  adc_sar u_sar (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(start),
    .tick(tick),
    .comp_hi(comp_hi),
    .dac_code(sar_code),
    .busy(busy),
    .done(sar_done),
    .result(sar_result)
  );

  // control register: enable and channel, written together
  always_comb begin
    nxt_en = en_ff;
    nxt_ch = ch_ff;
    if (wr_ctrl) begin
      // enable takes the written value at once; a start in the same write
      // still sees the old enable
      nxt_en = io_wdata[`ADC_CTRL_EN_BIT];
      // reserved channel codes are stored as written and switch no input
      nxt_ch = io_wdata[`ADC_CTRL_CH_HI:`ADC_CTRL_CH_LO];
      // bits 1..0 are not stored, software keeps them zero
    end
  end

  // control register flops, cleared to disabled on channel zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_ff <= 1'b0;
      ch_ff <= `ADC_CH_RST;
    end else begin
      en_ff <= nxt_en;
      ch_ff <= nxt_ch;
    end
  end

  // clock divider register: write only, so nothing here feeds the read mux
  always_comb begin
    nxt_div = div_ff;
    if (wr_div) begin
      // reserved divide codes are stored and then act as the slowest rate
      // a new code written mid-conversion changes the tick rate at once
      nxt_div = io_wdata[`ADC_DIV_HI:`ADC_DIV_LO];
    end
  end

  // divider flops, reset to divide by one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= `ADC_DIV_RST;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // reference control register: select field and output enable
  always_comb begin
    nxt_rsel = rsel_ff;
    nxt_rout = rout_ff;
    if (wr_ref) begin
      // reserved select codes are stored but route nothing to the pin
      nxt_rsel = io_wdata[`ADC_REF_SEL_HI:`ADC_REF_SEL_LO];
      // routing follows one cycle later through the switch flops
      nxt_rout = io_wdata[`ADC_REF_OUT_BIT];
      // bits 3..1 are not stored, software keeps them zero
    end
  end

  // reference control flops, reset to supply level with the pin released
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsel_ff <= `ADC_REF_SEL_RST;
      rout_ff <= 1'b0;
    end else begin
      rsel_ff <= nxt_rsel;
      rout_ff <= nxt_rout;
    end
  end

  // completion flag and result; writes to the result address never reach here
  always_comb begin
    nxt_done = done_ff;
    nxt_res = res_ff;
    if (start) begin
      // a start restarts the engine, so a completion in the same cycle
      // belongs to the discarded conversion and is dropped with it
      nxt_done = 1'b0;
    end else if (sar_done) begin
      // flag and result move on the same edge, so a poll that sees the
      // flag always reads a complete result
      nxt_done = 1'b1;
      nxt_res = sar_result;
    end
    // disabling aborts nothing: a conversion in flight still finishes and
    // loads its result, only new starts are held off
  end

  // flag and result flops; the result clears to zero until a conversion lands
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
      res_ff <= 8'h00;
    end else begin
      done_ff <= nxt_done;
      res_ff <= nxt_res;
    end
  end

  // read mux, registered so read data is a flop output
  always_comb begin
    nxt_rdata = 8'h00;
    if (io_rd) begin
      unique case (io_addr)
        `ADC_CTRL_ADDR: begin
          // bit 6 reads the done flag, never the start request itself
          // reserved low bits read zero whatever software wrote there
          nxt_rdata = {en_ff, done_ff, ch_ff, 2'b00};
        end
        `ADC_RESULT_ADDR: begin
          // holds the last finished result until the next one lands
          nxt_rdata = res_ff;
        end
        `ADC_REF_CTRL_ADDR: begin
          // reserved bits 3..1 are not stored and read zero
          nxt_rdata = {rsel_ff, 3'b000, rout_ff};
        end
        default: begin
          // divider address reads zero since it is write only
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  // read data flop, zero between reads so a stale value never lingers
  // the cost is one cycle of read latency, which the processor port allows
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // reference routing: at most one switch closes, chosen by the select field
  always_comb begin
    nxt_pb1 = 1'b0;
    nxt_bg = 1'b0;
    nxt_tick = tick; // outside view of the converter clock, one cycle late
    if (rout_ff) begin
      unique case (rsel_ff)
        adc_pkg::ADC_REF_PB1: begin
          nxt_pb1 = 1'b1;
        end
        adc_pkg::ADC_REF_BG: begin
          nxt_bg = 1'b1;
        end
        default: begin
          // supply level and reserved codes keep both switches open
          nxt_pb1 = 1'b0;
          nxt_bg = 1'b0;
        end
      endcase
    end
  end

  // analog control flops, one cycle after the source state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pb1_ff <= 1'b0;
      bg_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      pb1_ff <= nxt_pb1;
      bg_ff <= nxt_bg;
      tick_ff <= nxt_tick;
    end
  end

  // outputs straight from flops; the trial code comes from the engine's own
  // flop, so at divide by one the comparator still judges the code under trial
  // rather than the one before it
  assign io_rdata = rdata_ff;
  assign dac_code = sar_code;
  assign adc_enable = en_ff;
  assign chan_sel = ch_ff;
  assign ref_sel = rsel_ff;
  assign ref_out_pb1 = pb1_ff;
  assign ref_out_bg = bg_ff;
  assign adc_clk_tick = tick_ff;
endmodule : adc_ctrl
`default_nettype wire

// ===== testbench/adc_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
// watches the register port and control outputs of the converter block
module adc_ctrl_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic comp_hi,
  input wire logic [7:0] dac_code,
  input wire logic adc_enable,
  input wire logic [3:0] chan_sel,
  input wire logic [3:0] ref_sel,
  input wire logic ref_out_pb1,
  input wire logic ref_out_bg,
  input wire logic adc_clk_tick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // a write to the control register
  sequence s_ctl_wr;
    io_wr && io_addr == 6'h20;
  endsequence
  // start while enabled, and start while disabled with no converter tick in that cycle
  sequence s_go_on;
    s_ctl_wr ##0 io_wdata[6] && adc_enable;
  endsequence
  sequence s_go_off;
    s_ctl_wr ##0 io_wdata[6] && !adc_enable && !adc_clk_tick;
  endsequence
  chk_enable_write: assert property (s_ctl_wr |=> adc_enable == $past(io_wdata[7]))
    else $error("enable bit wrong");
  chk_chan_write: assert property (s_ctl_wr |=> chan_sel == $past(io_wdata[5:2]))
    else $error("channel wrong");
  chk_ref_write: assert property (io_wr && io_addr == 6'h1C |=> ref_sel == $past(io_wdata[7:4]))
    else $error("reference select wrong");
  chk_div_hidden: assert property (io_rd && io_addr == 6'h21 |=> io_rdata == 8'h00)
    else $error("divider readable");
  chk_ctl_read: assert property (io_rd && !io_wr && io_addr == 6'h20 |=>
    io_rdata[7] == $past(adc_enable) && io_rdata[1:0] == 2'h0)
    else $error("control readback wrong");
  chk_route_pin1: assert property (ref_out_pb1 |-> $past(ref_sel) == 4'h1)
    else $error("pin 1 routed wrongly");
  chk_route_bg: assert property (ref_out_bg |-> $past(ref_sel) == 4'h2 && !ref_out_pb1)
    else $error("band-gap routed wrongly");
  chk_start_ticks: assert property (s_go_on |-> ##[1:300] adc_clk_tick)
    else $error("started conversion never ticks");
  chk_start_off: assert property (s_go_off |=> !adc_clk_tick [*4])
    else $error("disabled start ran");
endmodule : adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk u_chk (.core_clk, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata,
  .io_rdata, .comp_hi, .dac_code, .adc_enable, .chan_sel, .ref_sel, .ref_out_pb1,
  .ref_out_bg, .adc_clk_tick);
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0, rst_b = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, io_rdata, dac_code, tgt = 8'h00, rv;
  logic [3:0] chan_sel, ref_sel;
  logic comp_hi, adc_enable, ref_out_pb1, ref_out_bg, adc_clk_tick;
  int err_count = 0, checks_done = 0, cyc = 0, gap = 0, last = 0, n;
  // analog input sits half a step above tgt, so no trial code ever ties
  assign comp_hi = {tgt, 1'b1} > {dac_code, 1'b0};
  always #20 core_clk = ~core_clk;
  adc_ctrl u_dut (.core_clk, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .comp_hi, .dac_code, .adc_enable, .chan_sel, .ref_sel, .ref_out_pb1, .ref_out_bg,
    .adc_clk_tick);
  // cycle count, last tick spacing, and a hang limit well past the longest run
  always @(posedge core_clk) begin
    cyc++;
    if (adc_clk_tick) begin
      gap = cyc - last;
      last = cyc;
    end
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one write: strobe held over exactly one taking edge
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
  endtask : wr
  // one read: data stands only the cycle after the taking edge
  task rd(input logic [5:0] a);
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1 rv = io_rdata;
  endtask : rd
  task t_reset;
    rd(6'h20);
    cmp(rv, 8'h00);
    rd(6'h1C);
    cmp(rv, 8'h00);
    rd(6'h21);
    cmp(rv, 8'h00);
  endtask : t_reset
  // each channel code paired with one divide code, done flag polled
  task t_convert;
    logic [3:0] ch [8];
    ch = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9, 4'hF};
    wr(6'h20, 8'h80);
    for (int i = 0; i < 8; i++) begin
      wr(6'h21, {3'h0, 4'(i), 1'b0});
      tgt <= 8'h5A ^ 8'(i * 37);
      rd(6'h21);
      cmp(rv, 8'h00);
      wr(6'h20, {2'h3, ch[i], 2'h0});
      rd(6'h20);
      cmp({7'h0, rv[6]}, 8'h00);
      cmp({4'h0, chan_sel}, {4'h0, ch[i]});
      n = 0;
      while (rv[6] !== 1'b1 && n < 900) begin
        rd(6'h20);
        n++;
      end
      cmp({7'h0, rv[6]}, 8'h01);
      cmp(8'(gap), 8'(1 << i));
      rd(6'h22);
      cmp(rv, tgt);
      wr(6'h22, ~tgt);
      rd(6'h22);
      cmp(rv, tgt);
    end
  endtask : t_convert
  // start in the same write that enables: must be ignored
  task t_disabled;
    int k;
    k = 0;
    wr(6'h20, 8'h00);
    wr(6'h20, 8'hC0);
    repeat (40) begin
      @(posedge core_clk);
      k += adc_clk_tick;
    end
    cmp(8'(k), 8'h00);
    cmp({7'h0, adc_enable}, 8'h01);
    rd(6'h20);
    cmp(rv, 8'hC0);
  endtask : t_disabled
  task t_ref;
    for (int s = 0; s < 3; s++) begin
      wr(6'h1C, {4'(s), 4'h1});
      rd(6'h1C);
      cmp(rv, {4'(s), 4'h1});
      cmp({7'h0, ref_out_pb1}, {7'h0, s == 1});
      cmp({7'h0, ref_out_bg}, {7'h0, s == 2});
    end
    wr(6'h1C, 8'h20);
    rd(6'h1C);
    cmp({6'h0, ref_out_pb1, ref_out_bg}, 8'h00);
  endtask : t_ref
  task end_sim;
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_convert();
    t_disabled();
    t_ref();
    end_sim();
  end
endmodule : tb
`default_nettype wire
